// >>> ext_irq_pkg.sv
// Package with register map, field layout and polarity codes of the edge timestamp block
package ext_irq_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int CHANNELS = 3;
    localparam int CNT_W    = 16;
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 5;
    localparam int BE_W     = DATA_W / 8;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_CFG0 = 16'h7070;
    localparam logic [15:0] IDX_CTR0 = 16'h7078;
    localparam logic [15:0] IDX_STAT = 16'h7080;
    localparam logic [15:0] IDX_MASK = 16'h7081;
    // Local word offsets seen on the bus address port
    localparam logic [ADDR_W-1:0] OFF_CFG0 = ADDR_W'(IDX_CFG0 - IDX_CFG0);
    localparam logic [ADDR_W-1:0] OFF_CTR0 = ADDR_W'(IDX_CTR0 - IDX_CFG0);
    localparam logic [ADDR_W-1:0] OFF_STAT = ADDR_W'(IDX_STAT - IDX_CFG0);
    localparam logic [ADDR_W-1:0] OFF_MASK = ADDR_W'(IDX_MASK - IDX_CFG0);

    // ----------------------------------------------------------------
    // Configuration fields and reset values
    // ----------------------------------------------------------------
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_POL_LO = 2;
    localparam int CFG_POL_HI = 3;
    localparam logic [1:0] POL_FALL_A = 2'h0;
    localparam logic [1:0] POL_RISE   = 2'h1;
    localparam logic [1:0] POL_FALL_B = 2'h2;
    localparam logic [1:0] POL_BOTH   = 2'h3;
    localparam logic [1:0]          POL_RESET = 2'h0;
    localparam logic [CNT_W-1:0]    CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0]    CNT_ONE   = 16'h0001;
    localparam logic [CHANNELS-1:0] EVT_RESET = 3'h0;
    localparam logic [DATA_W-1:0]   RD_ZERO   = 32'h0000_0000;

    // Decides whether a detected transition matches the polarity code
    function automatic logic edge_match(input logic [1:0] pol, input logic rise,
                                        input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (pol)
            POL_FALL_A, POL_FALL_B: hit = fall;
            POL_RISE:               hit = rise;
            POL_BOTH:               hit = rise | fall;
        endcase
        return hit;
    endfunction

endpackage

// >>> irq_chan_if.sv
// Interface carrying one channel's settings, edge event and count between modules
`timescale 1ns/1ns
interface irq_chan_if;
    import ext_irq_pkg::*;

    logic             enable;     // Channel enabled
    logic [1:0]       polarity;   // Edge selection code
    logic             valid_edge; // One-cycle pulse on a qualifying edge
    logic [CNT_W-1:0] count;      // Timestamp count

    modport ctrl_mp (output enable, output polarity, input valid_edge, input count);
    modport edge_mp (input enable, input polarity, output valid_edge);
    modport cnt_mp  (input enable, input valid_edge, output count);
endinterface

// >>> irq_edge_detect.sv
// Pin synchroniser and polarity-selected edge detector for one channel
`timescale 1ns/1ns
module irq_edge_detect
    import ext_irq_pkg::*;
(
    input  wire logic clock,     // System clock
    input  wire logic rst_b,     // Synchronous reset, active low
    input  wire logic pin,       // Asynchronous interrupt pin
    irq_chan_if.edge_mp chan     // Channel settings and edge pulse
);
    logic sync1_q;
    logic sync2_q;
    logic last_q;
    logic edge_q;
    logic rise;
    logic fall;
    logic hit;

    // Transition decode from the second stage and its delayed copy
    assign rise = sync2_q & ~last_q;
    assign fall = ~sync2_q & last_q;
    assign hit  = chan.enable & edge_match(chan.polarity, rise, fall);
    assign chan.valid_edge = edge_q;

    // Two-stage synchroniser, then a history flop for edge detection
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
            edge_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
            edge_q  <= hit;
        end
    end

    rise_detect_a: assert property (@(posedge clock) disable iff (!rst_b)
        (chan.enable && chan.polarity == POL_RISE && rise) |=> edge_q)
        else $error("rising edge missed");
    fall_ignore_a: assert property (@(posedge clock) disable iff (!rst_b)
        (chan.polarity == POL_RISE && fall) |=> !edge_q)
        else $error("falling edge taken in rising mode");
    disabled_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
        !chan.enable |=> !edge_q)
        else $error("edge reported on disabled channel");
endmodule

// >>> irq_timestamp_counter.sv
// Sixteen-bit timestamp counter for one channel
`timescale 1ns/1ns
module irq_timestamp_counter
    import ext_irq_pkg::*;
(
    input  wire logic clock,     // System clock
    input  wire logic rst_b,     // Synchronous reset, active low
    irq_chan_if.cnt_mp chan      // Enable and edge in, count out
);
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // Clear on edge, else step while enabled, else hold; wraps naturally
    assign count_d = chan.valid_edge ? CNT_RESET
                   : chan.enable     ? CNT_W'(count_q + CNT_ONE)
                   :                   count_q;
    assign chan.count = count_q;

    // Count register, cleared only by reset or a valid edge
    always_ff @(posedge clock)
    begin
        if (!rst_b)
            count_q <= CNT_RESET;
        else
            count_q <= count_d;
    end
endmodule

// >>> ext_irq_timestamp.sv
// Three-channel external interrupt front end with timestamp counters
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
module ext_irq_timestamp
    import ext_irq_pkg::*;
(
    input  wire logic              clock,           // System clock, 100 MHz
    input  wire logic              rst_b,           // Synchronous reset, active low
    input  wire logic [ADDR_W-1:0] avs_address,     // Word offset from first config
    input  wire logic              avs_read,        // Read request
    input  wire logic              avs_write,       // Write request
    input  wire logic [DATA_W-1:0] avs_writedata,   // Write data
    input  wire logic [BE_W-1:0]   avs_byteenable,  // Byte lanes of a write
    output logic [DATA_W-1:0]      avs_readdata,    // Read data
    output logic                   avs_waitrequest, // Stall for the current request
    input  wire logic [CHANNELS-1:0] irq_pin,       // External interrupt pins
    output logic [CHANNELS-1:0]    irq_pulse,       // Per-edge request pulses
    output logic                   irq              // Masked summary interrupt
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [CHANNELS-1:0] enable_q;
    logic [CHANNELS-1:0] enable_d;
    logic [1:0]          pol_q [CHANNELS];
    logic [1:0]          pol_d [CHANNELS];
    logic [CHANNELS-1:0] status_q;
    logic [CHANNELS-1:0] status_d;
    logic [CHANNELS-1:0] mask_q;
    logic [CHANNELS-1:0] mask_d;
    logic                ack_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rdata_d;

    // ----------------------------------------------------------------
    // Per-channel views gathered from the interfaces
    // ----------------------------------------------------------------
    logic [CNT_W-1:0]    count_w [CHANNELS];
    logic [CHANNELS-1:0] edge_w;
    logic [CHANNELS-1:0] hit_cfg;
    logic [CHANNELS-1:0] hit_ctr;
    logic                hit_stat;
    logic                hit_mask;
    logic                req;
    logic                wr_take;
    logic                rd_sample;
    logic                lane0;
    logic                hit_any;

    // Clock and reset shared by the checks that leave both out
    default clocking chk_clk @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Word offset of register k in a bank that starts at base
    function automatic logic [ADDR_W-1:0] bank_off(input logic [ADDR_W-1:0] base,
                                                   input int k);
        return ADDR_W'(base + ADDR_W'(k));
    endfunction

    // Config word image: enable, polarity, zero elsewhere
    function automatic logic [DATA_W-1:0] cfg_word(input logic en, input logic [1:0] pol);
        logic [DATA_W-1:0] w;
        w = RD_ZERO;
        w[CFG_EN_BIT]            = en;
        w[CFG_POL_HI:CFG_POL_LO] = pol;
        return w;
    endfunction

    // ----------------------------------------------------------------
    // Bus handshake: one stall cycle, answer on the second edge
    // ----------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_take         = avs_write & ack_q;
    assign rd_sample       = avs_read & ~ack_q;
    assign lane0           = avs_byteenable[0];
    assign avs_readdata    = rdata_q;

    // Address decode for the two banks and the event registers
    assign hit_stat = (avs_address == OFF_STAT);
    assign hit_mask = (avs_address == OFF_MASK);
    // Any mapped register; everything else is the reserved space
    assign hit_any  = (|hit_cfg) | (|hit_ctr) | hit_stat | hit_mask;

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    irq_chan_if ch [CHANNELS] ();

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++)
        begin : g_chan
            // Bank decode: configs consecutive, counters after the gap
            assign hit_cfg[i] = (avs_address == bank_off(OFF_CFG0, i));
            assign hit_ctr[i] = (avs_address == bank_off(OFF_CTR0, i));

            // Settings to the channel, events and counts back
            assign ch[i].enable   = enable_q[i];
            assign ch[i].polarity = pol_q[i];
            assign edge_w[i]      = ch[i].valid_edge;
            assign count_w[i]     = ch[i].count;

            // Config write: only bits 0 and 3:2 are stored
            assign enable_d[i] = (wr_take && hit_cfg[i] && lane0)
                               ? avs_writedata[CFG_EN_BIT] : enable_q[i];
            assign pol_d[i]    = (wr_take && hit_cfg[i] && lane0)
                               ? avs_writedata[CFG_POL_HI:CFG_POL_LO] : pol_q[i];

            irq_edge_detect u_edge
            (
                .clock (clock),
                .rst_b (rst_b),
                .pin   (irq_pin[i]),
                .chan  (ch[i])
            );

            irq_timestamp_counter u_cnt
            (
                .clock (clock),
                .rst_b (rst_b),
                .chan  (ch[i])
            );

            // Configuration registers
            always_ff @(posedge clock)
            begin
                if (!rst_b)
                begin
                    enable_q[i] <= 1'b0;
                    pol_q[i]    <= POL_RESET;
                end
                else
                begin
                    enable_q[i] <= enable_d[i];
                    pol_q[i]    <= pol_d[i];
                end
            end

            enable_write_a: assert property (@(posedge clock) disable iff (!rst_b)
                (wr_take && hit_cfg[i] && lane0) |=> enable_q[i] == $past(avs_writedata[0]))
                else $error("enable bit not written");
            count_inc_a: assert property (@(posedge clock) disable iff (!rst_b)
                (enable_q[i] && !edge_w[i]) |=> count_w[i] == CNT_W'($past(count_w[i]) + 1))
                else $error("enabled counter did not step by one");
            edge_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
                edge_w[i] |=> count_w[i] == CNT_RESET ##1 (!enable_q[i] || edge_w[i]
                    || count_w[i] == CNT_ONE))
                else $error("counter not cleared and restarted on edge");
            hold_stop_a: assert property (@(posedge clock) disable iff (!rst_b)
                (!enable_q[i] && !edge_w[i]) |=> $stable(count_w[i]))
                else $error("disabled counter moved");
            count_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
                (enable_q[i] && !edge_w[i] && count_w[i] == '1) |=> count_w[i] == CNT_RESET)
                else $error("counter did not wrap to zero");
            status_set_a: assert property (@(posedge clock) disable iff (!rst_b)
                irq_pulse[i] |=> status_q[i])
                else $error("edge event not latched in status");
            ctr_read_a: assert property (@(posedge clock) disable iff (!rst_b)
                (rd_sample && hit_ctr[i]) |=> !avs_waitrequest
                    && avs_readdata == {{(DATA_W-CNT_W){1'b0}}, $past(count_w[i])})
                else $error("counter read returned wrong value");
            cfg_read_a: assert property (@(posedge clock) disable iff (!rst_b)
                (rd_sample && hit_cfg[i]) |=> avs_readdata[1] == 1'b0
                    && avs_readdata[3:2] == $past(pol_q[i]) && avs_readdata[0] == $past(enable_q[i]))
                else $error("config readback wrong");

            // Field writes, reserved bits and the sticky event bit
            pol_write_a: assert property (
                (wr_take && hit_cfg[i] && lane0) |=> pol_q[i] == $past(avs_writedata[3:2]))
                else $error("polarity field not written");

            pol_lane_a: assert property (
                (wr_take && hit_cfg[i] && !lane0) |=> $stable(pol_q[i]))
                else $error("polarity written without lane zero");

            cfg_upper_a: assert property (
                (rd_sample && hit_cfg[i]) |=> avs_readdata[DATA_W-1:4] == '0)
                else $error("config upper bits not zero");

            stat_clear_a: assert property (
                (wr_take && hit_stat && lane0 && avs_writedata[i] && !edge_w[i]) |=> !status_q[i])
                else $error("status bit not cleared");

            stat_sticky_a: assert property (
                (status_q[i] && !(wr_take && hit_stat && lane0 && avs_writedata[i])) |=> status_q[i])
                else $error("status bit lost");

            irq_set_a: assert property (
                irq_pulse[i] |=> (!mask_q[i] || irq))
                else $error("unmasked event gave no interrupt");

            // Reset clears the count whatever the channel did before
            cnt_reset_a: assert property (disable iff (1'b0)
                !rst_b |=> count_w[i] == CNT_RESET && !irq_pulse[i])
                else $error("counter not zero after reset");


            edge_seen_c:  cover property (@(posedge clock) disable iff (!rst_b)
                edge_w[i] ##1 count_w[i] == CNT_RESET);
            wrap_seen_c:  cover property (@(posedge clock) disable iff (!rst_b)
                enable_q[i] && count_w[i] == '1 ##1 count_w[i] == CNT_RESET);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Request pulses toward the processor interrupt logic
    // ----------------------------------------------------------------
    assign irq_pulse = edge_w;

    // ----------------------------------------------------------------
    // Event status and mask; a new event beats a same-cycle clear
    // ----------------------------------------------------------------
    assign status_d = (status_q & ~((wr_take && hit_stat && lane0)
                    ? avs_writedata[CHANNELS-1:0] : EVT_RESET)) | edge_w;
    assign mask_d   = (wr_take && hit_mask && lane0)
                    ? avs_writedata[CHANNELS-1:0] : mask_q;
    assign irq      = |(status_q & mask_q);

    // Status and mask registers
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            status_q <= EVT_RESET;
            mask_q   <= EVT_RESET;
        end
        else
        begin
            status_q <= status_d;
            mask_q   <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data selection; unmapped offsets read zero
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_d = RD_ZERO;
        for (int k = 0; k < CHANNELS; k++)
        begin
            if (hit_cfg[k])
                rdata_d = cfg_word(enable_q[k], pol_q[k]);
            if (hit_ctr[k])
                rdata_d = {{(DATA_W-CNT_W){1'b0}}, count_w[k]};
        end
        if (hit_stat)
            rdata_d = {{(DATA_W-CHANNELS){1'b0}}, status_q};
        if (hit_mask)
            rdata_d = {{(DATA_W-CHANNELS){1'b0}}, mask_q};
    end

    // Handshake flop and read data capture on the stall cycle
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ack_q   <= 1'b0;
            rdata_q <= RD_ZERO;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (rd_sample)
                rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks on the bus and the interrupt path
    // ----------------------------------------------------------------
    wait_one_a: assert property (@(posedge clock) disable iff (!rst_b)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus stalled longer than one cycle");
    clear_race_a: assert property (@(posedge clock) disable iff (!rst_b)
        (wr_take && hit_stat && lane0 && |edge_w) |=> |status_q)
        else $error("event lost against status clear");
    irq_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
        (mask_q == EVT_RESET) |-> !irq)
        else $error("interrupt raised while fully masked");

    // ----------------------------------------------------------------
    // Register map and handshake checks on the default clocking
    // ----------------------------------------------------------------
    unmapped_zero_a: assert property (
        (rd_sample && !hit_any) |=> avs_readdata == RD_ZERO)
        else $error("unmapped offset read nonzero");

    gap_write_a: assert property (
        (wr_take && !hit_any) |=> $stable(mask_q) && $stable(enable_q))
        else $error("write to unmapped offset took effect");

    stat_read_a: assert property (
        (rd_sample && hit_stat) |=> avs_readdata[CHANNELS-1:0] == $past(status_q))
        else $error("status readback wrong");

    mask_read_a: assert property (
        (rd_sample && hit_mask) |=> avs_readdata[CHANNELS-1:0] == $past(mask_q))
        else $error("mask readback wrong");

    mask_write_a: assert property (
        (wr_take && hit_mask && lane0) |=> mask_q == $past(avs_writedata[CHANNELS-1:0]))
        else $error("mask not written");

    lane_guard_a: assert property (
        (wr_take && !lane0) |=> $stable(mask_q) && $stable(enable_q))
        else $error("write without lane zero took effect");

    // Read data stands until the next read is sampled
    rdata_hold_a: assert property (
        !rd_sample |=> $stable(avs_readdata))
        else $error("read data moved without a read");

    ack_drop_a: assert property (
        (req && !avs_waitrequest) |=> !ack_q)
        else $error("handshake flop stuck high");

    // Reset leaves the bus idle and the interrupt low
    reset_quiet_a: assert property (disable iff (1'b0)
        !rst_b |=> !irq && !ack_q && status_q == EVT_RESET && avs_readdata == RD_ZERO)
        else $error("state not cleared by reset");

    bus_read_c:  cover property (@(posedge clock) disable iff (!rst_b)
        avs_read && avs_waitrequest ##1 avs_read && !avs_waitrequest);
    irq_seen_c:  cover property (@(posedge clock) disable iff (!rst_b)
        !irq ##1 irq);
    both_edge_c: cover property (@(posedge clock) disable iff (!rst_b)
        edge_w[0] && pol_q[0] == POL_BOTH);

endmodule

// >>> pin_source.sv
// Behavioural model of the external pin drivers and the processor interrupt logic
`timescale 1ns/1ns
module pin_source
    import ext_irq_pkg::*;
(
    input  wire logic                     clock,     // System clock
    input  wire logic                     rst_b,     // Synchronous reset, active low
    input  wire logic [CHANNELS-1:0]      level,     // Pin levels asked by the bench
    input  wire logic [CHANNELS-1:0]      irq_pulse, // Request pulses from the block
    output logic [CHANNELS-1:0]           irq_pin,   // Driven pin levels
    output logic [CHANNELS-1:0][7:0]      hits       // Pulses seen per channel
);
    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    // Pins change just after an edge and hold each level for whole cycles
    always_ff @(posedge clock)
    begin
        irq_pin <= level;
    end

    // ----------------------------------------------------------------
    // Interrupt receiver
    // ----------------------------------------------------------------
    // A pulse longer than one cycle is counted more than once
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < CHANNELS; i++)
        begin
            if (!rst_b)
                hits[i] <= 8'h00;
            else if (irq_pulse[i])
                hits[i] <= hits[i] + 8'h01;
        end
    end
endmodule

// >>> test_ext_irq_timestamp.sv
// Self-checking testbench for the three-channel edge timestamp block
`timescale 1ns/1ns
module test_ext_irq_timestamp
    import ext_irq_pkg::*;
;
    typedef struct packed {logic [1:0] pol; logic rise; logic exp;} row_s;

    logic                        clock = 1'b0;
    logic                        rst_b = 1'b0;
    logic [ADDR_W-1:0]           avs_address = '0;
    logic                        avs_read = 1'b0;
    logic                        avs_write = 1'b0;
    logic [DATA_W-1:0]           avs_writedata = '0;
    logic [BE_W-1:0]             avs_byteenable = 4'hf;
    logic [DATA_W-1:0]           avs_readdata;
    logic                        avs_waitrequest;
    logic [CHANNELS-1:0]         pin_level = 3'h0;
    logic [CHANNELS-1:0]         irq_pin;
    logic [CHANNELS-1:0]         irq_pulse;
    logic                        irq;
    logic [CHANNELS-1:0][7:0]    hits;
    logic [DATA_W-1:0]           a;
    logic [DATA_W-1:0]           b;
    logic [7:0]                  base;
    int                          failures = 0;
    int                          n_tests = 0;
    row_s                        rows [8] = '{
        '{POL_FALL_A, 1'b1, 1'b0}, '{POL_FALL_A, 1'b0, 1'b1},
        '{POL_RISE,   1'b1, 1'b1}, '{POL_RISE,   1'b0, 1'b0},
        '{POL_FALL_B, 1'b1, 1'b0}, '{POL_FALL_B, 1'b0, 1'b1},
        '{POL_BOTH,   1'b1, 1'b1}, '{POL_BOTH,   1'b0, 1'b1}};

    // ----------------------------------------------------------------
    // Clock, design and partner
    // ----------------------------------------------------------------
    always #5 clock = ~clock;

    ext_irq_timestamp uut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_pin(irq_pin), .irq_pulse(irq_pulse),
        .irq(irq));

    pin_source src (.clock(clock), .rst_b(rst_b), .level(pin_level),
        .irq_pulse(irq_pulse), .irq_pin(irq_pin), .hits(hits));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low at an edge
    task automatic await_ack();
        do
        begin
            @(posedge clock);
        end
        while (avs_waitrequest !== 1'b0);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] adr, input logic [31:0] d,
                      input logic [BE_W-1:0] be = 4'hf);
        @(posedge clock);
        avs_address <= adr;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        await_ack();
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] adr, output logic [31:0] d);
        @(posedge clock);
        avs_address <= adr;
        avs_read <= 1'b1;
        await_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (100000) @(posedge clock);
        failures++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        // Reset values of all configs and counters
        for (int i = 0; i < CHANNELS; i++)
        begin
            rd(OFF_CFG0 + 5'(i), a);
            check("config reset", a, 32'h0);
            rd(OFF_CTR0 + 5'(i), a);
            check("counter reset", a, 32'h0);
        end
        // Every polarity code against both edge directions on channel 0
        foreach (rows[r])
        begin
            wr(OFF_CFG0, {28'h0, rows[r].pol, 2'b10});
            pin_level[0] <= ~rows[r].rise;
            repeat (5) @(posedge clock);
            wr(OFF_CFG0, {28'h0, rows[r].pol, 2'b11});
            rd(OFF_CFG0, a);
            check("config", a, {28'h0, rows[r].pol, 2'b01});
            base = hits[0];
            pin_level[0] <= rows[r].rise;
            repeat (8) @(posedge clock);
            check("pulses", 32'(hits[0] - base), 32'(rows[r].exp));
        end
        // Sticky status, mask and write-one-to-clear
        rd(OFF_STAT, a);
        check("status", a, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        wr(OFF_MASK, 32'h1);
        @(negedge clock);
        check("irq unmasked", 32'(irq), 32'h1);
        wr(OFF_STAT, 32'h1);
        @(negedge clock);
        check("irq cleared", 32'(irq), 32'h0);
        rd(OFF_STAT, a);
        check("status cleared", a, 32'h0);
        // Channel 1: counting, holding while disabled, read-only counter
        wr(OFF_CFG0 + 5'h1, {28'h0, POL_RISE, 2'b01});
        rd(OFF_CTR0 + 5'h1, a);
        rd(OFF_CTR0 + 5'h1, b);
        check("count step", b - a, 32'h3);
        wr(OFF_CFG0 + 5'h1, 32'h0);
        rd(OFF_CTR0 + 5'h1, a);
        repeat (10) @(posedge clock);
        base = hits[1];
        pin_level[1] <= 1'b1;
        repeat (8) @(posedge clock);
        check("disabled pulses", 32'(hits[1] - base), 32'h0);
        rd(OFF_CTR0 + 5'h1, b);
        check("held count", b, a);
        wr(OFF_CTR0 + 5'h1, 32'h0000_ffff);
        rd(OFF_CTR0 + 5'h1, b);
        check("counter write", b, a);
        wr(OFF_CFG0 + 5'h1, 32'h0000_0001, 4'h0);
        rd(OFF_CFG0 + 5'h1, b);
        check("no lane write", b, 32'h0);
        wr(5'h05, 32'h0000_000f);
        rd(5'h05, b);
        check("reserved gap", b, 32'h0);
        // Channel 2: edge clears the counter, then a full wrap
        wr(OFF_CFG0 + 5'h2, {28'h0, POL_RISE, 2'b01});
        repeat (20) @(posedge clock);
        pin_level[2] <= 1'b1;
        for (int n = 0; n < 20 && irq_pulse[2] !== 1'b1; n++)
            @(posedge clock);
        rd(OFF_CTR0 + 5'h2, a);
        check("cleared count", a, 32'h1);
        repeat (65540) @(posedge clock);
        rd(OFF_CTR0 + 5'h2, b);
        check("wrapped count", b, 32'h8);
        rd(OFF_STAT, a);
        check("status ch2", a, 32'h4);
        check("irq ch2 masked", 32'(irq), 32'h0);
        wrap_up();
    end
endmodule
